//--- include/port_wake_regs.svh
// Register indices, reset values and field positions of the port wake block
`ifndef PORT_WAKE_REGS_SVH
`define PORT_WAKE_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define PW_IDX_C1_VID_LOW    6'h05
`define PW_IDX_C2_TAG_HIGH   6'h06
`define PW_IDX_C2_VID_LOW    6'h07
`define PW_IDX_C1_LAYER_TYPE 6'h08
`define PW_IDX_C2_LAYER_TYPE 6'h0a
`define PW_IDX_WAKE_FLAGS    6'h13
`define PW_IDX_WAKE_ENABLES  6'h17
`define PW_IDX_IRQ_SUMMARY   6'h1b
`define PW_IDX_IRQ_MASK      6'h1f

// Reset values
`define PW_RST_C1_VID_LOW    8'h02
`define PW_RST_C2_TAG_HIGH   8'h40
`define PW_RST_C2_VID_LOW    8'h03
`define PW_RST_LAYER_TYPE    16'h88b5
`define PW_RST_EVENT_BITS    3'h0

// Tag high byte fields
`define PW_TAG_PRIO_MSB      7
`define PW_TAG_PRIO_LSB      5
`define PW_TAG_CANON_FMT_BIT 4
`define PW_TAG_VIDHI_MSB     3
`define PW_TAG_VIDHI_LSB     0

// Wake event and enable bits
`define PW_WAKE_MAGIC_BIT    2
`define PW_WAKE_LINK_BIT     1
`define PW_WAKE_ENERGY_BIT   0

// Interrupt summary and mask bits
`define PW_IRQ_TS_BIT        2
`define PW_IRQ_PHY_BIT       1
`define PW_IRQ_ACL_BIT       0

`endif

//--- include/port_wake_pkg.sv
// Types shared by the port wake and interrupt register block
package port_wake_pkg;
    typedef logic [7:0]  reg8_type;
    typedef logic [15:0] reg16_type;
    typedef logic [2:0]  event_bits_type;
    typedef logic [47:0] mac_addr_type;
    typedef logic [5:0]  reg_index_type;
endpackage

//--- logic/port_wake_event_interrupt_regs.sv
// Per-port reservation class, wake event and interrupt summary registers
//
// Overview of operation
// [RL1] Class 2 tag high: priority 7-5, format flag 4, VID 11-8; reset 0x40.
// [RL2] Class 1 tag low byte holds VID 7-0, read-write, reset 0x02.
// [RL3] Class 2 tag low byte holds VID 7-0, read-write, reset 0x03.
// [RL4] Class 1 EtherType is 16-bit read-write, reset 0x88B5.
// [RL5] Class 2 EtherType is 16-bit read-write, reset 0x88B5.
// [RL6] Magic packet counts only when its destination equals the switch MAC.
// [RL7] Qualifying magic packet sets wake flag bit 2; writing one clears it.
// [RL8] Link up sets wake flag bit 1, only on ports with a PHY.
// [RL9] Cable energy sets wake flag bit 0, only with a PHY; write clears.
// [RL10] Enable bit 2 lets magic packet detection drive the wake pin.
// [RL11] Enable bit 1 lets link-up detection drive the wake pin.
// [RL12] Enable bit 0 lets energy detection drive the wake pin.
// [RL13] Summary bits raise the interrupt only when their mask allows.
// [RL14] Summary bit 2 is the OR of timestamp flags, PHY ports only.
// [RL15] Summary bit 1 is the OR of PHY interrupt flags, PHY ports only.
// [RL16] Summary bit 0 is the sticky access-list counter interrupt, all ports.
// [RL17] Software clears the access-list status by toggling its mask bit.
// [RL18] Mask bit zero enables, one disables; all mask bits reset to zero.
// [RL19] Wake flags hold until written; pin stays active while one is enabled.
// [RL20] Reserved bits read zero and ignore writes.
//
// Chosen here: the APB interface to the registers.
`include "port_wake_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module port_wake_event_interrupt_regs #(
    parameter bit PORT_HAS_PHY = 1'h1,
    parameter int TS_FLAGS_W   = 8,
    parameter int PHY_FLAGS_W  = 8
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire port_wake_pkg::mac_addr_type switchMacAddr,
    input  wire logic                        magicDetect,
    input  wire port_wake_pkg::mac_addr_type magicDestAddr,
    input  wire logic                        linkUpDetect,
    input  wire logic                        energyDetect,
    input  wire logic [TS_FLAGS_W-1:0]       tsIrqFlags,
    input  wire logic [PHY_FLAGS_W-1:0]      phyIrqFlags,
    input  wire logic                        aclIrqEvent,
    output logic                             wakeEventPin,
    output logic                             portIrq
);

    // Reset release synchroniser
    logic [1:0] rstSync_q;
    logic       rstSyncB;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'h1};
        end
    end
    assign rstSyncB = rstSync_q[1];

    // Register storage
    port_wake_pkg::reg8_type       c1VidLow_q;
    port_wake_pkg::reg8_type       c2TagHigh_q;
    port_wake_pkg::reg8_type       c2VidLow_q;
    port_wake_pkg::reg16_type      c1Type_q;
    port_wake_pkg::reg16_type      c2Type_q;
    port_wake_pkg::event_bits_type wakeFlags_q;
    port_wake_pkg::event_bits_type wakeFlags_d;
    port_wake_pkg::event_bits_type wakeEn_q;
    port_wake_pkg::event_bits_type wakeEn_d;
    port_wake_pkg::event_bits_type irqStatus_q;
    port_wake_pkg::event_bits_type irqStatus_d;
    port_wake_pkg::event_bits_type irqMask_q;
    port_wake_pkg::event_bits_type irqMask_d;
    logic [31:0]                   prdata_q;
    logic                          slvErr_q;
    logic                          wakePin_q;
    logic                          portIrq_q;

    // Bus decode
    port_wake_pkg::reg_index_type  regIdx;
    logic hitC1Vid;
    logic hitC2Tag;
    logic hitC2Vid;
    logic hitC1Type;
    logic hitC2Type;
    logic hitFlags;
    logic hitEn;
    logic hitStatus;
    logic hitMask;
    logic mapped;
    logic setupPhase;
    logic wrAccess;
    logic wrLo;
    logic wrHi;
    logic [31:0] rdMux;

    assign regIdx     = paddr[7:2];
    assign hitC1Vid   = (regIdx == `PW_IDX_C1_VID_LOW);
    assign hitC2Tag   = (regIdx == `PW_IDX_C2_TAG_HIGH);
    assign hitC2Vid   = (regIdx == `PW_IDX_C2_VID_LOW);
    assign hitC1Type  = (regIdx == `PW_IDX_C1_LAYER_TYPE);
    assign hitC2Type  = (regIdx == `PW_IDX_C2_LAYER_TYPE);
    assign hitFlags   = (regIdx == `PW_IDX_WAKE_FLAGS);
    assign hitEn      = (regIdx == `PW_IDX_WAKE_ENABLES);
    assign hitStatus  = (regIdx == `PW_IDX_IRQ_SUMMARY);
    assign hitMask    = (regIdx == `PW_IDX_IRQ_MASK);
    assign mapped     = hitC1Vid | hitC2Tag | hitC2Vid | hitC1Type
                      | hitC2Type | hitFlags | hitEn | hitStatus | hitMask;
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pready & pwrite & ~slvErr_q;
    assign wrLo       = wrAccess & pstrb[0];
    assign wrHi       = wrAccess & pstrb[1];

    // Narrow registers sit in the low bits, the rest reads zero
    assign rdMux = hitC1Vid  ? {24'h00_0000, c1VidLow_q} :             // RL2
                   hitC2Tag  ? {24'h00_0000, c2TagHigh_q} :            // RL1
                   hitC2Vid  ? {24'h00_0000, c2VidLow_q} :             // RL3
                   hitC1Type ? {16'h0000, c1Type_q} :                  // RL4
                   hitC2Type ? {16'h0000, c2Type_q} :                  // RL5
                   hitFlags  ? {29'h0000_0000, wakeFlags_q} :          // RL20
                   hitEn     ? {29'h0000_0000, wakeEn_q} :
                   hitStatus ? {29'h0000_0000, irqStatus_q} :
                   hitMask   ? {29'h0000_0000, irqMask_q} :
                               32'h0000_0000;

    // Zero wait states; read data and error are captured in the setup cycle
    // An unmapped index answers with an error and its write is dropped
    assign pready  = 1'h1;
    assign prdata  = prdata_q;
    assign pslverr = psel & penable & slvErr_q;

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            prdata_q <= 32'h0000_0000;
            slvErr_q <= 1'h0;
        end else if (setupPhase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
            slvErr_q <= ~mapped;
        end
    end

    // Reservation class tag and EtherType registers
    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            c1VidLow_q  <= `PW_RST_C1_VID_LOW;                         // RL2
            c2TagHigh_q <= `PW_RST_C2_TAG_HIGH;                        // RL1
            c2VidLow_q  <= `PW_RST_C2_VID_LOW;                         // RL3
            c1Type_q    <= `PW_RST_LAYER_TYPE;                         // RL4
            c2Type_q    <= `PW_RST_LAYER_TYPE;                         // RL5
        end else begin
            if (wrLo && hitC1Vid) begin
                c1VidLow_q <= pwdata[7:0];
            end
            if (wrLo && hitC2Tag) begin
                c2TagHigh_q <= pwdata[7:0];
            end
            if (wrLo && hitC2Vid) begin
                c2VidLow_q <= pwdata[7:0];
            end
            if (wrLo && hitC1Type) begin
                c1Type_q[7:0] <= pwdata[7:0];
            end
            if (wrHi && hitC1Type) begin
                c1Type_q[15:8] <= pwdata[15:8];
            end
            if (wrLo && hitC2Type) begin
                c2Type_q[7:0] <= pwdata[7:0];
            end
            if (wrHi && hitC2Type) begin
                c2Type_q[15:8] <= pwdata[15:8];
            end
        end
    end

    // Wake events; link and energy exist only on ports with a PHY
    port_wake_pkg::event_bits_type phyBits;
    port_wake_pkg::event_bits_type eventIn;
    port_wake_pkg::event_bits_type flagClear;
    logic                          magicHit;

    assign phyBits   = {1'h1, PORT_HAS_PHY, PORT_HAS_PHY};
    assign magicHit  = magicDetect & (magicDestAddr == switchMacAddr); // RL6
    assign eventIn   = {magicHit, linkUpDetect, energyDetect}
                     & phyBits;                                  // RL7 RL8 RL9
    assign flagClear = (wrLo && hitFlags) ? pwdata[2:0]
                                          : `PW_RST_EVENT_BITS;
    // A new event wins over a clear in the same cycle
    assign wakeFlags_d = (wakeFlags_q & ~flagClear) | eventIn;        // RL19
    assign wakeEn_d    = (wrLo && hitEn) ? (pwdata[2:0] & phyBits)
                                         : wakeEn_q;                  // RL20

    // Pin follows flags and enables at the same edge they update
    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            wakeFlags_q <= `PW_RST_EVENT_BITS;
            wakeEn_q    <= `PW_RST_EVENT_BITS;
            wakePin_q   <= 1'h0;
        end else begin
            wakeFlags_q <= wakeFlags_d;
            wakeEn_q    <= wakeEn_d;
            wakePin_q   <= |(wakeFlags_d & wakeEn_d);     // RL10 RL11 RL12
        end
    end
    assign wakeEventPin = wakePin_q;

    // Interrupt summary and mask
    // Access-list status is read-only; a change of its mask bit clears it
    logic aclClear;

    assign irqMask_d = (wrLo && hitMask) ? pwdata[2:0] : irqMask_q;   // RL18
    assign aclClear  = wrLo & hitMask
                     & (pwdata[`PW_IRQ_ACL_BIT]
                        != irqMask_q[`PW_IRQ_ACL_BIT]);              // RL17
    assign irqStatus_d[`PW_IRQ_TS_BIT]  = PORT_HAS_PHY & (|tsIrqFlags);
    assign irqStatus_d[`PW_IRQ_PHY_BIT] = PORT_HAS_PHY & (|phyIrqFlags);
    assign irqStatus_d[`PW_IRQ_ACL_BIT] = aclIrqEvent
        | (irqStatus_q[`PW_IRQ_ACL_BIT] & ~aclClear);                // RL16

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            irqStatus_q <= `PW_RST_EVENT_BITS;
            irqMask_q   <= `PW_RST_EVENT_BITS;                        // RL18
            portIrq_q   <= 1'h0;
        end else begin
            irqStatus_q <= irqStatus_d;                         // RL14 RL15
            irqMask_q   <= irqMask_d;
            portIrq_q   <= |(irqStatus_d & ~irqMask_d);               // RL13
        end
    end
    assign portIrq = portIrq_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSyncB);

    a_tag_reset_values: assert property (                     // RL1 RL2 RL3
        $rose(rstSyncB) |-> c2TagHigh_q == 8'h40 && c1VidLow_q == 8'h02
                            && c2VidLow_q == 8'h03)
        else $error("Tag bytes left reset with wrong values");

    a_type_reset_values: assert property (                          // RL4 RL5
        $rose(rstSyncB) |-> c1Type_q == 16'h88b5 && c2Type_q == 16'h88b5)
        else $error("EtherType registers left reset with wrong values");

    a_magic_match_sets: assert property (                           // RL6 RL7
        magicDetect && magicDestAddr == switchMacAddr
        |=> wakeFlags_q[2])
        else $error("Matching magic packet did not set its flag");

    a_magic_mismatch_ignored: assert property (                          // RL6
        magicDetect && magicDestAddr != switchMacAddr && !wakeFlags_q[2]
        |=> !wakeFlags_q[2])
        else $error("Magic packet to another address set the flag");

    a_link_energy_set: assert property (                            // RL8 RL9
        linkUpDetect || energyDetect
        |=> (wakeFlags_q[1] == PORT_HAS_PHY || !$past(linkUpDetect))
            && (wakeFlags_q[0] == PORT_HAS_PHY || !$past(energyDetect)))
        else $error("Link or energy event handled wrongly for port type");

    a_flag_holds: assert property (                                     // RL19
        wakeFlags_q[2] && !(wrLo && hitFlags) |=> wakeFlags_q[2])
        else $error("Wake flag dropped without a clearing write");

    a_pin_on_event: assert property (                   // RL7 RL10
        magicHit && wakeEn_q[2] && !(wrLo && hitEn) |=> wakeEventPin)
        else $error("Enabled magic packet did not drive the wake pin");

    a_acl_irq_raise: assert property (                         // RL13 RL16
        aclIrqEvent && !irqMask_q[0] && !(wrLo && hitMask)
        |=> portIrq && irqStatus_q[0])
        else $error("Unmasked access-list event raised no interrupt");

    a_acl_toggle_clear: assert property (                      // RL17 RL18
        wrLo && hitMask && pwdata[0] != irqMask_q[0] && !aclIrqEvent
        |=> !irqStatus_q[0])
        else $error("Toggling the access-list mask did not clear status");

    a_summary_bits: assert property (                          // RL14
        |tsIrqFlags && PORT_HAS_PHY |=> irqStatus_q[2])
        else $error("Timestamp flags not reported in summary");

    a_reserved_zero: assert property (                                  // RL20
        setupPhase && !pwrite && hitFlags |=> prdata[31:3] == 29'h0)
        else $error("Reserved wake flag bits read nonzero");

    // Wake flag, enable and pin checks
    a_set_beats_clear: assert property (                         // RL19
        |eventIn |=> (wakeFlags_q & $past(eventIn)) == $past(eventIn))
        else $error("Wake event lost against a clearing write");

    a_flag_write_clear: assert property (                    // RL7 RL9
        wrLo && hitFlags && eventIn == 3'h0
        |=> (wakeFlags_q & $past(pwdata[2:0])) == 3'h0)
        else $error("Writing one to a wake flag did not clear it");

    a_link_sets: assert property (                                // RL8
        linkUpDetect && PORT_HAS_PHY
        |=> wakeFlags_q[`PW_WAKE_LINK_BIT])
        else $error("Link up on a PHY port did not set its flag");

    a_energy_sets: assert property (                              // RL9
        energyDetect && PORT_HAS_PHY
        |=> wakeFlags_q[`PW_WAKE_ENERGY_BIT])
        else $error("Cable energy on a PHY port did not set its flag");

    a_enable_write: assert property (               // RL10 RL11 RL12
        wrLo && hitEn |=> wakeEn_q == ($past(pwdata[2:0]) & phyBits))
        else $error("Wake enable write not stored");

    a_pin_matches_flags: assert property (                       // RL19
        wakeEventPin == |(wakeFlags_q & wakeEn_q))
        else $error("Wake pin disagrees with the enabled flags");

    // Summary and mask checks
    a_irq_matches_mask: assert property (                        // RL13
        portIrq == |(irqStatus_q & ~irqMask_q))
        else $error("Port interrupt disagrees with status and mask");

    a_mask_write: assert property (                              // RL18
        wrLo && hitMask |=> irqMask_q == $past(pwdata[2:0]))
        else $error("Interrupt mask write not stored");

    a_phy_summary: assert property (                             // RL15
        PORT_HAS_PHY && (|phyIrqFlags) |=> irqStatus_q[`PW_IRQ_PHY_BIT])
        else $error("PHY flags not reported in summary");

    a_summary_drop: assert property (                       // RL14 RL15
        tsIrqFlags == '0 && phyIrqFlags == '0
        |=> irqStatus_q[`PW_IRQ_TS_BIT:`PW_IRQ_PHY_BIT] == 2'h0)
        else $error("Summary bit set without any source flag");

    a_acl_sticky: assert property (                              // RL16
        irqStatus_q[`PW_IRQ_ACL_BIT] && !aclClear
        |=> irqStatus_q[`PW_IRQ_ACL_BIT])
        else $error("Access-list status dropped without a mask toggle");

    // Register bus checks
    a_c1vid_write: assert property (                              // RL2
        wrLo && hitC1Vid |=> c1VidLow_q == $past(pwdata[7:0]))
        else $error("Class 1 VLAN low byte write not stored");

    a_c2tag_write: assert property (                              // RL1
        wrLo && hitC2Tag |=> c2TagHigh_q == $past(pwdata[7:0]))
        else $error("Class 2 tag high byte write not stored");

    a_c2vid_write: assert property (                              // RL3
        wrLo && hitC2Vid |=> c2VidLow_q == $past(pwdata[7:0]))
        else $error("Class 2 VLAN low byte write not stored");

    a_c1type_write: assert property (                             // RL4
        wrLo && wrHi && hitC1Type
        |=> c1Type_q == $past(pwdata[15:0]))
        else $error("Class 1 EtherType write not stored");

    a_c2type_write: assert property (                             // RL5
        wrLo && wrHi && hitC2Type
        |=> c2Type_q == $past(pwdata[15:0]))
        else $error("Class 2 EtherType write not stored");

    a_unmapped_error: assert property (                          // RL20
        psel && penable && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped access gave no error or nonzero data");

endmodule

`default_nettype wire

//--- bench/net_port_model.sv
// Network-side event source feeding the port wake register block
`timescale 1ns/100ps
`default_nettype none

module net_port_model (
    input  wire logic                        sys_clk,
    input  wire logic [2:0]                  eventReq,
    input  wire logic                        wrongDest,
    input  wire port_wake_pkg::mac_addr_type switchMacAddr,
    output logic                             magicDetect,
    output port_wake_pkg::mac_addr_type      magicDestAddr,
    output logic                             linkUpDetect,
    output logic                             energyDetect
);
    initial begin
        magicDetect = 1'b0;
        linkUpDetect = 1'b0;
        energyDetect = 1'b0;
        magicDestAddr = '0;
    end

    always @(posedge sys_clk) begin
        magicDetect <= eventReq[2];
        linkUpDetect <= eventReq[1];
        energyDetect <= eventReq[0];
        // Address means nothing outside the strobe, so keep it moving
        if (eventReq[2]) begin
            magicDestAddr <= wrongDest ? ~switchMacAddr : switchMacAddr;
        end else begin
            magicDestAddr <= ~magicDestAddr;
        end
    end
endmodule

`default_nettype wire

//--- bench/port_wake_event_interrupt_regs_tb.sv
// Self-checking bench of the port wake and interrupt register block
`include "port_wake_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module port_wake_event_interrupt_regs_tb;
    logic                        sys_clk = 1'b0;
    logic                        rst_b = 1'b0;
    logic                        psel = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite = 1'b0;
    logic [7:0]                  paddr = 8'h00;
    logic [31:0]                 pwdata = 32'h0000_0000;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    port_wake_pkg::mac_addr_type macAddr = 48'h0a1b_2c3d_4e5f;
    port_wake_pkg::mac_addr_type destAddr;
    logic                        magicDet;
    logic                        linkDet;
    logic                        energyDet;
    logic [2:0]                  eventReq = 3'h0;
    logic                        wrongDest = 1'b0;
    logic [7:0]                  tsFlags = 8'h00;
    logic [7:0]                  phyFlags = 8'h00;
    logic                        aclEvent = 1'b0;
    logic                        wakeEventPin;
    logic                        portIrq;
    logic                        macPin;
    logic                        macIrq;
    int                          errTotal = 0;
    int                          comparisons = 0;

    always #5 sys_clk = ~sys_clk;

    net_port_model partner (.sys_clk(sys_clk), .eventReq(eventReq),
        .wrongDest(wrongDest), .switchMacAddr(macAddr),
        .magicDetect(magicDet), .magicDestAddr(destAddr),
        .linkUpDetect(linkDet), .energyDetect(energyDet));

    port_wake_event_interrupt_regs uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .switchMacAddr(macAddr), .magicDetect(magicDet),
        .magicDestAddr(destAddr), .linkUpDetect(linkDet),
        .energyDetect(energyDet), .tsIrqFlags(tsFlags),
        .phyIrqFlags(phyFlags), .aclIrqEvent(aclEvent),
        .wakeEventPin(wakeEventPin), .portIrq(portIrq));

    // MAC-only port on the same bus and events; only its pins are judged
    port_wake_event_interrupt_regs #(.PORT_HAS_PHY(1'b0)) uutMac (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .pready(), .prdata(), .pslverr(), .switchMacAddr(macAddr),
        .magicDetect(magicDet), .magicDestAddr(destAddr),
        .linkUpDetect(linkDet), .energyDetect(energyDet),
        .tsIrqFlags(tsFlags), .phyIrqFlags(phyFlags), .aclIrqEvent(aclEvent),
        .wakeEventPin(macPin), .portIrq(macIrq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [5:0] idx,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic er);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        xfer(1'b1, idx, d, rd, er);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp,
                       input logic expErr = 1'b0);
        logic [31:0] rd;
        logic        er;
        xfer(1'b0, idx, 32'h0000_0000, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, expErr});
    endtask

    // Pins are read once the wait is over
    task automatic pin(input logic irq, input logic exp, input logic expMac);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, (irq ? portIrq : wakeEventPin)}, {31'h0, exp});
        chk({31'h0, (irq ? macIrq : macPin)}, {31'h0, expMac});
    endtask

    task automatic fire(input logic [2:0] kind, input logic bad);
        @(posedge sys_clk);
        eventReq <= kind;
        wrongDest <= bad;
        @(posedge sys_clk);
        eventReq <= 3'h0;
    endtask

    task automatic t_regs;
        rdc(`PW_IDX_C1_VID_LOW, 32'h0000_0002);
        rdc(`PW_IDX_C2_TAG_HIGH, 32'h0000_0040);
        rdc(`PW_IDX_C2_VID_LOW, 32'h0000_0003);
        rdc(`PW_IDX_C1_LAYER_TYPE, 32'h0000_88b5);
        rdc(`PW_IDX_C2_LAYER_TYPE, 32'h0000_88b5);
        rdc(`PW_IDX_IRQ_MASK, 32'h0000_0000);
        rdc(`PW_IDX_C2_TAG_HIGH, 32'h0000_0040);
        wr(`PW_IDX_C2_TAG_HIGH, 32'hffff_ffa5);
        rdc(`PW_IDX_C2_TAG_HIGH, 32'h0000_00a5);
        wr(`PW_IDX_C1_VID_LOW, 32'hffff_ff5a);
        rdc(`PW_IDX_C1_VID_LOW, 32'h0000_005a);
        wr(`PW_IDX_C2_VID_LOW, 32'h1234_56c3);
        rdc(`PW_IDX_C2_VID_LOW, 32'h0000_00c3);
        wr(`PW_IDX_C1_LAYER_TYPE, 32'hffff_1234);
        rdc(`PW_IDX_C1_LAYER_TYPE, 32'h0000_1234);
        wr(`PW_IDX_C2_LAYER_TYPE, 32'h0000_abcd);
        rdc(`PW_IDX_C2_LAYER_TYPE, 32'h0000_abcd);
        wr(`PW_IDX_IRQ_SUMMARY, 32'hffff_ffff);
        rdc(`PW_IDX_IRQ_SUMMARY, 32'h0000_0000);
        rdc(6'h00, 32'h0000_0000, 1'b1);
        $display("test regs done");
    endtask

    task automatic t_wake;
        fire(3'b100, 1'b1);
        rdc(`PW_IDX_WAKE_FLAGS, 32'h0000_0000);
        wr(`PW_IDX_WAKE_ENABLES, 32'hffff_ffff);
        rdc(`PW_IDX_WAKE_ENABLES, 32'h0000_0007);
        for (int i = 0; i < 3; i++) begin
            fire(3'b001 << i, 1'b0);
            pin(1'b0, 1'b1, (i == 2));
            wr(`PW_IDX_WAKE_FLAGS, 32'h0000_0000);
            rdc(`PW_IDX_WAKE_FLAGS, 32'h1 << i);
            pin(1'b0, 1'b1, (i == 2));
            wr(`PW_IDX_WAKE_FLAGS, 32'h1 << i);
            pin(1'b0, 1'b0, 1'b0);
        end
        wr(`PW_IDX_WAKE_ENABLES, 32'h0000_0000);
        fire(3'b111, 1'b0);
        pin(1'b0, 1'b0, 1'b0);
        rdc(`PW_IDX_WAKE_FLAGS, 32'h0000_0007);
        wr(`PW_IDX_WAKE_FLAGS, 32'h0000_0007);
        $display("test wake done");
    endtask

    task automatic t_irq;
        @(posedge sys_clk);
        tsFlags <= 8'h10;
        pin(1'b1, 1'b1, 1'b0);
        rdc(`PW_IDX_IRQ_SUMMARY, 32'h0000_0004);
        wr(`PW_IDX_IRQ_MASK, 32'h0000_0004);
        pin(1'b1, 1'b0, 1'b0);
        tsFlags <= 8'h00;
        phyFlags <= 8'h80;
        pin(1'b1, 1'b1, 1'b0);
        rdc(`PW_IDX_IRQ_SUMMARY, 32'h0000_0002);
        phyFlags <= 8'h00;
        pin(1'b1, 1'b0, 1'b0);
        aclEvent <= 1'b1;
        @(posedge sys_clk);
        aclEvent <= 1'b0;
        pin(1'b1, 1'b1, 1'b1);
        rdc(`PW_IDX_IRQ_SUMMARY, 32'h0000_0001);
        wr(`PW_IDX_IRQ_MASK, 32'h0000_0005);
        wr(`PW_IDX_IRQ_MASK, 32'h0000_0004);
        rdc(`PW_IDX_IRQ_SUMMARY, 32'h0000_0000);
        pin(1'b1, 1'b0, 1'b0);
        $display("test irq done");
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_wake();
        t_irq();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errTotal++;
        summarize();
    end
endmodule

`default_nettype wire
